// ---- src/cdcc_pkg.sv ----
// constants, encodings and register map of the clock distribution configuration block
// Overview of operation
// [R1] channel 1 divider has ratio-low, control and phase byte registers
// [R2] channel 2 divider has ratio-low, control and phase byte registers
// [R3] third output driver register: format, polarity, drive, enable like the first driver
// [R4] fourth output driver register: format, polarity, drive, enable like the first driver
// [R5] fifth output 3.3 V select resets to 0; then format field governs
// [R6] 3.3 V select set makes the fifth output a 3.3 V CMOS driver
// [R7] format field of the fifth output is ignored while 3.3 V select is set
// [R8] software sets 3.3 V select only when format already holds a CMOS code
// [R9] format 000 off/tristate, 001 HSTL (reset), 010 LVDS, 011/111 reserved
// [R10] format 100 both legs CMOS, 101 P leg only, 110 N leg only
// [R11] polarity 00 pos/neg, 01 pos/pos, 10 neg/pos, 11 neg/neg
// [R12] drive bit 0 low CMOS and 3.5 mA LVDS, 1 normal CMOS and boost
// [R13] CMOS drive strength applies only in 3.3 V mode; 1.8 V always low
// [R14] fifth output bit 0 enables the 1.8 V driver, resets disabled
// [R15] enable bit has no effect while 3.3 V select is set
// [R16] channel 3 divider 1 ratio low byte has own register, resets to 3
// [R17] every divider divides its input by ratio plus one
// [R18] control byte: bit 3 power down, bit 2 prescaler two, bits 1:0 ratio high
// [R19] phase is six bits, half input periods after sync, reset 0; divider drops the lsb and waits phase[5:1] whole input ticks
// [R20] register after channel 3 low byte holds its ratio bits 9:8, reset 0
// [R21] reserved bits read zero and ignore writes
package cdcc_pkg;
    localparam int        CDCC_NREG    = 11;
    localparam int        CDCC_AW      = 16;
    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_CH1_RATIO_LOW  = 14'h0507;
    localparam logic [13:0] IDX_CH1_CONTROL    = 14'h0508;
    localparam logic [13:0] IDX_CH1_PHASE      = 14'h0509;
    localparam logic [13:0] IDX_DRV3_SETTING   = 14'h050A;
    localparam logic [13:0] IDX_DRV4_SETTING   = 14'h050B;
    localparam logic [13:0] IDX_CH2_RATIO_LOW  = 14'h050C;
    localparam logic [13:0] IDX_CH2_CONTROL    = 14'h050D;
    localparam logic [13:0] IDX_CH2_PHASE      = 14'h050E;
    localparam logic [13:0] IDX_DRV5_SETTING   = 14'h050F;
    localparam logic [13:0] IDX_CH3_RATIO_LOW  = 14'h0510;
    localparam logic [13:0] IDX_CH3_RATIO_HIGH = 14'h0511;
    // slot numbers inside the register array (index minus first index)
    localparam int S_CH1_LO = 0, S_CH1_CT = 1, S_CH1_PH = 2, S_DRV3 = 3, S_DRV4 = 4;
    localparam int S_CH2_LO = 5, S_CH2_CT = 6, S_CH2_PH = 7, S_DRV5 = 8;
    localparam int S_CH3_LO = 9, S_CH3_HI = 10;
    // field positions
    localparam int CTL_PD_BIT   = 3;
    localparam int CTL_RF2_BIT  = 2;
    localparam int PHASE_W      = 6;
    localparam int DRV_33_BIT   = 7;
    localparam int DRV_FMT_LSB  = 4;
    localparam int DRV_POL_LSB  = 2;
    localparam int DRV_STR_BIT  = 1;
    localparam int DRV_EN_BIT   = 0;
    localparam logic [7:0] RATIO_LOW_RESET = 8'h00;
    // writable bits per slot; everything else is reserved and reads zero
    localparam logic [7:0] CDCC_WMASK [CDCC_NREG] = '{
        8'hFF, 8'h0F, 8'h3F, 8'h7F, 8'h7F, 8'hFF, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'h03};
    localparam logic [7:0] CDCC_RESET [CDCC_NREG] = '{
        RATIO_LOW_RESET, 8'h00, 8'h00, 8'h10, 8'h10, RATIO_LOW_RESET, 8'h00, 8'h00,
        8'h10, 8'h03, 8'h00};
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        FMT_OFF  = 3'h0, FMT_HSTL = 3'h1, FMT_LVDS = 3'h2, FMT_RSV3 = 3'h3,
        FMT_CMOS = 3'h4, FMT_CMOS_P = 3'h5, FMT_CMOS_N = 3'h6, FMT_RSV7 = 3'h7
    } cdcc_fmt_t;
endpackage

// ---- src/cdcc_divider.sv ----
// one channel divider: counts prescaler ticks, emits one pulse per ratio+1 ticks
`timescale 1ns/10ps
`default_nettype none
module cdcc_divider
    import cdcc_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire logic               tickIn,
    input  wire logic               syncPulse,
    input  wire logic               powerDown,
    input  wire logic [9:0]         ratio,
    input  wire logic [PHASE_W-1:0] phase,
    output logic                    divTick,
    output logic                    divLevel
);
    logic [9:0] cntQ;
    logic [4:0] holdQ;
    logic       wrapW;
    logic       runW;

    // >= instead of == so a ratio lowered mid-count still wraps at once
    assign wrapW = (cntQ >= ratio);
    assign runW  = tickIn && !powerDown && (holdQ == 5'h00);

    // the half-period lsb of the phase cannot be resolved on whole ticks
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cntQ     <= 10'h000;
            holdQ    <= 5'h00;
            divTick  <= 1'b0;
            divLevel <= 1'b0;
        end else if (powerDown) begin // [R18]
            cntQ     <= 10'h000;
            holdQ    <= 5'h00;
            divTick  <= 1'b0;
            divLevel <= 1'b0;
        end else if (syncPulse) begin
            cntQ     <= 10'h000;
            holdQ    <= phase[PHASE_W-1:1]; // [R19]
            divTick  <= 1'b0;
            divLevel <= 1'b0;
        end else begin
            divTick <= runW && wrapW; // [R17]
            if (tickIn && holdQ != 5'h00) begin
                holdQ <= holdQ - 5'h01;
            end
            if (runW) begin
                cntQ <= wrapW ? 10'h000 : cntQ + 10'h001;
                if (wrapW) begin
                    divLevel <= !divLevel;
                end
            end
        end
    end
endmodule // cdcc_divider
`default_nettype wire

// ---- src/cdcc_clock_distribution.sv ----
// register file over AXI4-Lite, channel dividers and output driver decode
`timescale 1ns/10ps
`default_nettype none
module cdcc_clock_distribution
    import cdcc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // axi4-lite slave
    input  wire logic [CDCC_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [CDCC_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // prescaler ticks and sync, one-cycle enables on core_clk
    input  wire logic              rf1Tick,
    input  wire logic              rf2Tick,
    input  wire logic              syncPulse,
    // channel divider outputs
    output logic [2:0]             chanTick,
    output logic [2:0]             chanLevel,
    output logic [1:0]             chanPowerDown,
    // output drivers: index 0 third, 1 fourth, 2 fifth
    output logic [2:0]             drvMode [3],
    output logic [2:0]             drvLegP,
    output logic [2:0]             drvLegN,
    output logic [2:0]             drvInvP,
    output logic [2:0]             drvInvN,
    output logic [2:0]             drvLvdsBoost,
    output logic                   fifthCmos33,
    output logic                   fifthStrongCmos
);
    logic [7:0]         regQ [CDCC_NREG];
    logic [CDCC_AW-1:0] awAddrQ;
    logic               awHeldQ;
    logic [7:0]         wByteQ;
    logic               wLaneQ;
    logic               wHeldQ;

    // write decode on the held address
    logic [13:0] wOffW;
    logic        wHitW;
    logic        doWriteW;
    logic [3:0]  wSlotW;
    assign wOffW    = awAddrQ[CDCC_AW-1:2] - IDX_CH1_RATIO_LOW;
    assign wHitW    = (awAddrQ[CDCC_AW-1:2] >= IDX_CH1_RATIO_LOW) && (wOffW < 14'(CDCC_NREG));
    assign wSlotW   = wOffW[3:0];
    assign doWriteW = awHeldQ && wHeldQ && !s_axi_bvalid;

    // read decode straight from the request address
    logic [13:0] rOffW;
    logic        rHitW;
    logic [7:0]  rByteW;
    assign rOffW  = s_axi_araddr[CDCC_AW-1:2] - IDX_CH1_RATIO_LOW;
    assign rHitW  = (s_axi_araddr[CDCC_AW-1:2] >= IDX_CH1_RATIO_LOW)
                    && (rOffW < 14'(CDCC_NREG));
    assign rByteW = rHitW ? regQ[rOffW[3:0]] : 8'h00;

    // channels take both sides at once only when no response is pending
    assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
    assign s_axi_wready  = !wHeldQ && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // address and data may come in either order; each is held until both are here
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            awAddrQ <= '0;
            awHeldQ <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awAddrQ <= s_axi_awaddr;
            awHeldQ <= 1'b1;
        end else if (doWriteW) begin
            awHeldQ <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wByteQ <= 8'h00;
            wLaneQ <= 1'b0;
            wHeldQ <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wByteQ <= s_axi_wdata[7:0];
            wLaneQ <= s_axi_wstrb[0];
            wHeldQ <= 1'b1;
        end else if (doWriteW) begin
            wHeldQ <= 1'b0;
        end
    end

    // write response; unmapped addresses answer slverr and change nothing
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWriteW) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wHitW ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register array; only lane 0 carries a register byte
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < CDCC_NREG; i++) begin
                regQ[i] <= CDCC_RESET[i]; // [R5] [R14] [R16] [R19] [R20]
            end
        end else if (doWriteW && wHitW && wLaneQ) begin
            regQ[wSlotW] <= wByteQ & CDCC_WMASK[wSlotW]; // [R21]
        end
    end

    // read channel, data registered on acceptance
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rByteW}; // [R21]
            s_axi_rresp  <= rHitW ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // channel divider settings
    logic [9:0]         ratioW [3];
    logic [PHASE_W-1:0] phaseW [3];
    logic [2:0]         pdW;
    logic [2:0]         tickW;
    assign ratioW[0] = {regQ[S_CH1_CT][1:0], regQ[S_CH1_LO]}; // [R1] [R18]
    assign ratioW[1] = {regQ[S_CH2_CT][1:0], regQ[S_CH2_LO]}; // [R2] [R18]
    assign ratioW[2] = {regQ[S_CH3_HI][1:0], regQ[S_CH3_LO]}; // [R16] [R20]
    assign phaseW[0] = regQ[S_CH1_PH][PHASE_W-1:0]; // [R1] [R19]
    assign phaseW[1] = regQ[S_CH2_PH][PHASE_W-1:0]; // [R2] [R19]
    assign phaseW[2] = '0;
    assign pdW       = {1'b0, regQ[S_CH2_CT][CTL_PD_BIT], regQ[S_CH1_CT][CTL_PD_BIT]}; // [R18]
    // prescaler select; channel 3 select lives outside this block, so it uses the first
    assign tickW[0]  = regQ[S_CH1_CT][CTL_RF2_BIT] ? rf2Tick : rf1Tick; // [R18]
    assign tickW[1]  = regQ[S_CH2_CT][CTL_RF2_BIT] ? rf2Tick : rf1Tick; // [R18]
    assign tickW[2]  = rf1Tick;
    assign chanPowerDown = pdW[1:0];

    // three identical dividers: channel 1, channel 2, channel 3 divider 1
    for (genvar c = 0; c < 3; c++) begin : gChan
        cdcc_divider uDiv (
            .core_clk  (core_clk),
            .rstn      (rstn),
            .tickIn    (tickW[c]),
            .syncPulse (syncPulse),
            .powerDown (pdW[c]),
            .ratio     (ratioW[c]),
            .phase     (phaseW[c]),
            .divTick   (chanTick[c]),
            .divLevel  (chanLevel[c])
        );
    end

    // driver field extraction
    logic [7:0] drvRegW [3];
    logic [2:0] fmtW    [3];
    logic [1:0] polW    [3];
    logic [2:0] modeW   [3];
    logic [2:0] cmosW;
    logic       cmos33W;
    assign drvRegW[0] = regQ[S_DRV3]; // [R3]
    assign drvRegW[1] = regQ[S_DRV4]; // [R4]
    assign drvRegW[2] = regQ[S_DRV5];
    assign cmos33W    = regQ[S_DRV5][DRV_33_BIT]; // [R6]

    // effective mode: disabled or reserved code means powered down and tristated
    for (genvar d = 0; d < 3; d++) begin : gDrv
        logic enW;
        logic validW;
        assign fmtW[d]  = drvRegW[d][DRV_FMT_LSB+2:DRV_FMT_LSB];
        assign polW[d]  = drvRegW[d][DRV_POL_LSB+1:DRV_POL_LSB];
        assign enW      = drvRegW[d][DRV_EN_BIT]; // [R3] [R4] [R14]
        assign validW   = (fmtW[d] != FMT_RSV3) && (fmtW[d] != FMT_RSV7); // [R9]
        assign modeW[d] = (enW && validW) ? fmtW[d] : FMT_OFF; // [R9]
        assign cmosW[d] = modeW[d][2];
    end

    // fifth output in 3.3 V mode ignores format and enable and runs both legs
    logic [2:0] effModeW [3];
    assign effModeW[0] = modeW[0];
    assign effModeW[1] = modeW[1];
    assign effModeW[2] = cmos33W ? FMT_CMOS : modeW[2]; // [R6] [R7] [R15]

    // leg activity per mode; hstl and lvds drive both legs
    function automatic logic [1:0] legs(input logic [2:0] m);
        case (m)
            FMT_HSTL, FMT_LVDS, FMT_CMOS: legs = 2'b11; // [R9] [R10]
            FMT_CMOS_P:                   legs = 2'b10; // [R10]
            FMT_CMOS_N:                   legs = 2'b01; // [R10]
            default:                      legs = 2'b00; // [R9]
        endcase
    endfunction

    logic [2:0] legPW;
    logic [2:0] legNW;
    logic [2:0] invPW;
    logic [2:0] invNW;
    logic [2:0] boostW;
    logic [1:0] lgW [3];
    for (genvar d = 0; d < 3; d++) begin : gLeg
        logic polOnW;
        assign lgW[d]    = legs(effModeW[d]);
        assign legPW[d]  = lgW[d][1];
        assign legNW[d]  = lgW[d][0];
        // third and fourth apply polarity in cmos only; fifth whenever a leg is active
        assign polOnW    = (d == 2) ? (lgW[d] != 2'b00) : cmosW[d];
        assign invPW[d]  = polOnW && polW[d][1]; // [R11]
        assign invNW[d]  = polOnW && !(polW[d][1] ^ polW[d][0]); // [R11]
        assign boostW[d] = (effModeW[d] == FMT_LVDS) && drvRegW[d][DRV_STR_BIT]; // [R12]
    end

    // strong cmos only exists on the 3.3 V path; 1.8 V cmos stays at low drive
    logic strongW;
    assign strongW = cmos33W && regQ[S_DRV5][DRV_STR_BIT]; // [R12] [R13]

    // driver controls leave through flip-flops, one cycle after the register write
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int d = 0; d < 3; d++) begin
                drvMode[d] <= FMT_OFF;
            end
            drvLegP         <= 3'h0;
            drvLegN         <= 3'h0;
            drvInvP         <= 3'h0;
            drvInvN         <= 3'h0;
            drvLvdsBoost    <= 3'h0;
            fifthCmos33     <= 1'b0;
            fifthStrongCmos <= 1'b0;
        end else begin
            for (int d = 0; d < 3; d++) begin
                drvMode[d] <= effModeW[d];
            end
            drvLegP         <= legPW;
            drvLegN         <= legNW;
            drvInvP         <= invPW;
            drvInvN         <= invNW;
            drvLvdsBoost    <= boostW;
            fifthCmos33     <= cmos33W; // [R5] [R6]
            fifthStrongCmos <= strongW; // [R13]
        end
    end
endmodule // cdcc_clock_distribution
`default_nettype wire

// ---- tb/cdcc_sva.sv ----
// concurrent checks on the ports of the clock distribution configuration block
`timescale 1ns/10ps
`default_nettype none
module cdcc_sva
    import cdcc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [2:0]  chanTick,
    input wire logic [1:0]  chanPowerDown,
    input wire logic [2:0]  drvMode [3],
    input wire logic [2:0]  drvLegP,
    input wire logic [2:0]  drvLegN,
    input wire logic [2:0]  drvLvdsBoost,
    input wire logic        fifthCmos33,
    input wire logic        fifthStrongCmos
);
    // one clock domain, so clocking and reset are stated once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // read steps: request taken, then answer waiting for the master
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    // two cycles in power down, so a tick launched before it cannot count
    sequence s_pd_two;
        chanPowerDown[0] [*2];
    endsequence
    a_read_latency: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read answer missing one cycle after request");
    a_read_stands: assert property (
        s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before it was taken");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_write_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_ready_gap: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_mode33_both: assert property (
        fifthCmos33 |-> drvMode[2] == FMT_CMOS && drvLegP[2] && drvLegN[2])
        else $error("fifth output not cmos in 3.3 V mode");
    a_strong_only33: assert property (fifthStrongCmos |-> fifthCmos33)
        else $error("strong cmos drive outside 3.3 V mode");
    a_boost_lvds: assert property (drvLvdsBoost[2] |-> drvMode[2] == FMT_LVDS)
        else $error("lvds boost outside lvds mode");
    a_p_leg_only: assert property (drvMode[2] == FMT_CMOS_P |-> drvLegP[2] && !drvLegN[2])
        else $error("p-only cmos leg decode wrong");
    a_pd_silent: assert property (s_pd_two |-> !chanTick[0])
        else $error("powered down channel still ticks");
endmodule // cdcc_sva
bind cdcc_clock_distribution cdcc_sva u_sva (
    .core_clk(core_clk), .rstn(rstn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .chanTick(chanTick), .chanPowerDown(chanPowerDown),
    .drvMode(drvMode), .drvLegP(drvLegP), .drvLegN(drvLegN), .drvLvdsBoost(drvLvdsBoost),
    .fifthCmos33(fifthCmos33), .fifthStrongCmos(fifthStrongCmos));
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking testbench for the clock distribution configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import cdcc_pkg::*;
;
    logic               core_clk, rstn, rf1Tick, rf2Tick, syncPulse;
    logic [CDCC_AW-1:0] awaddr, araddr;
    logic               awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, chanPowerDown;
    logic [2:0]         chanTick, chanLevel, drvLegP, drvLegN, drvInvP, drvInvN, drvLvdsBoost;
    logic [2:0]         drvMode [3];
    logic               fifthCmos33, fifthStrongCmos;
    logic [5:0]         fifthW;
    int                 num_errors, num_checks, lag, tickCnt [3];
    localparam logic [7:0] RST_TAB [11] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h00, 8'h00,
                                            8'h00, 8'h10, 8'h03, 8'h00};
    localparam logic [7:0] MSK_TAB [11] = '{8'hFF, 8'h0F, 8'h3F, 8'h7F, 8'h7F, 8'hFF, 8'h0F,
                                            8'h3F, 8'hFF, 8'hFF, 8'h03};
    localparam logic [7:0] D5_VAL [7] = '{8'h41, 8'h40, 8'hC2, 8'hD0, 8'h43, 8'h23, 8'h21};
    localparam logic [5:0] D5_EXP [7] = '{6'h04, 6'h00, 6'h34, 6'h24, 6'h04, 6'h0A, 6'h02};
    localparam logic [1:0] LEG_TAB [8] = '{2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
    // fifth output: select, strong, boost, mode
    assign fifthW = {fifthCmos33, fifthStrongCmos, drvLvdsBoost[2], drvMode[2]};

    cdcc_clock_distribution u_dut (
        .core_clk(core_clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rf1Tick(rf1Tick), .rf2Tick(rf2Tick), .syncPulse(syncPulse), .chanTick(chanTick),
        .chanLevel(chanLevel), .chanPowerDown(chanPowerDown), .drvMode(drvMode),
        .drvLegP(drvLegP), .drvLegN(drvLegN), .drvInvP(drvInvP), .drvInvN(drvInvN),
        .drvLvdsBoost(drvLvdsBoost), .fifthCmos33(fifthCmos33), .fifthStrongCmos(fifthStrongCmos));

    // 100 ns period clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // divider pulse counters, sampled mid-cycle where outputs are settled
    always @(negedge core_clk) begin
        foreach (tickCnt[k]) if (chanTick[k] === 1'b1) tickCnt[k]++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // handshakes are sampled at the falling edge and released after the next rising edge
    task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        logic a, w, b;
        int   n;
        n = 0;
        @(posedge core_clk);
        awaddr  <= {idx, 2'h0};
        wdata   <= {24'h000000, d};
        wstrb   <= st;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= (lag == 0);
        do begin
            @(negedge core_clk);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            if (b) chk(32'(bresp), 32'(er));
            @(posedge core_clk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            bready <= !b && n >= lag && n < 39;
            n++;
        end while (!b && n < 40);
        if (!b) chk(32'h0, 32'h1);
    endtask

    task automatic rd(input logic [13:0] idx, input logic [7:0] ed, input logic [1:0] er);
        logic a, r;
        int   n;
        n = 0;
        @(posedge core_clk);
        araddr  <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= (lag == 0);
        do begin
            @(negedge core_clk);
            a = arvalid && arready;
            r = rvalid && rready;
            if (r) chk(rdata, {24'h000000, ed});
            if (r) chk(32'(rresp), 32'(er));
            @(posedge core_clk);
            if (a) arvalid <= 1'b0;
            rready <= !r && n >= lag && n < 39;
            n++;
        end while (!r && n < 40);
        if (!r) chk(32'h0, 32'h1);
    endtask

    // sync all dividers, then feed n rf1 ticks and n/2 rf2 ticks
    task automatic run(input int n);
        @(posedge core_clk);
        syncPulse <= 1'b1;
        @(posedge core_clk);
        syncPulse <= 1'b0;
        tickCnt = '{0, 0, 0};
        repeat (n) begin
            rf1Tick <= 1'b1;
            rf2Tick <= !rf2Tick;
            @(posedge core_clk);
        end
        rf1Tick <= 1'b0;
        rf2Tick <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        #1000000;
        num_errors++;
        final_report();
    end

    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, rf1Tick, rf2Tick, syncPulse} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        num_errors = 0;
        num_checks = 0;
        lag = 0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            rd(14'(14'h0507 + i), RST_TAB[i], RESP_OKAY);
        end
        lag = 3;
        rd(14'h0506, 8'h00, RESP_SLVERR);
        wr(14'h0512, 8'hFF, 4'hF, RESP_SLVERR);
        lag = 0;
        chk(32'({fifthCmos33, drvMode[2]}), 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 11; i++) begin
            wr(14'(14'h0507 + i), 8'hFF, 4'hF, RESP_OKAY);
            rd(14'(14'h0507 + i), MSK_TAB[i], RESP_OKAY);
            wr(14'(14'h0507 + i), 8'h00, 4'hE, RESP_OKAY);
            rd(14'(14'h0507 + i), MSK_TAB[i], RESP_OKAY);
        end
        $display("test register access done");
        for (int f = 0; f < 8; f++) begin
            wr(IDX_DRV5_SETTING, 8'(f * 16 + 1), 4'hF, RESP_OKAY);
            repeat (2) @(negedge core_clk);
            chk(32'(drvMode[2]), (f == 3 || f == 7) ? 32'h0 : 32'(f));
            chk(32'({drvLegP[2], drvLegN[2]}), 32'(LEG_TAB[f]));
        end
        for (int p = 0; p < 4; p++) begin
            wr(IDX_DRV5_SETTING, 8'(8'h41 + p * 4), 4'hF, RESP_OKAY);
            repeat (2) @(negedge core_clk);
            chk(32'({drvInvP[2], drvInvN[2]}), 32'({p[1], p[1] == p[0]}));
        end
        foreach (D5_VAL[i]) begin
            wr(IDX_DRV5_SETTING, D5_VAL[i], 4'hF, RESP_OKAY);
            repeat (2) @(negedge core_clk);
            chk(32'(fifthW), 32'(D5_EXP[i]));
        end
        wr(IDX_DRV3_SETTING, 8'h41, 4'hF, RESP_OKAY);
        wr(IDX_DRV4_SETTING, 8'h21, 4'hF, RESP_OKAY);
        repeat (2) @(negedge core_clk);
        chk(32'({drvMode[0], drvMode[1]}), 32'h22);
        chk(32'({drvLegP[1:0], drvInvP[1:0], drvInvN[1:0]}), 32'h31);
        $display("test output drivers done");
        wr(IDX_CH1_RATIO_LOW, 8'h02, 4'hF, RESP_OKAY);
        wr(IDX_CH1_CONTROL, 8'h00, 4'hF, RESP_OKAY);
        wr(IDX_CH1_PHASE, 8'h00, 4'hF, RESP_OKAY);
        wr(IDX_CH2_RATIO_LOW, 8'h04, 4'hF, RESP_OKAY);
        wr(IDX_CH2_CONTROL, 8'h04, 4'hF, RESP_OKAY);
        wr(IDX_CH2_PHASE, 8'h00, 4'hF, RESP_OKAY);
        wr(IDX_CH3_RATIO_LOW, 8'h03, 4'hF, RESP_OKAY);
        wr(IDX_CH3_RATIO_HIGH, 8'h00, 4'hF, RESP_OKAY);
        run(60);
        chk(tickCnt[0], 32'h14);
        chk(tickCnt[1], 32'h6);
        chk(tickCnt[2], 32'hF);
        chk(32'(chanLevel), 32'h4);
        wr(IDX_CH1_CONTROL, 8'h08, 4'hF, RESP_OKAY);
        wr(IDX_CH2_PHASE, 8'h04, 4'hF, RESP_OKAY);
        run(60);
        chk(tickCnt[0], 32'h0);
        chk(tickCnt[1], 32'h5);
        chk(32'(chanPowerDown), 32'h1);
        $display("test dividers done");
        final_report();
    end
endmodule // tb_top
`default_nettype wire
